//--- design/hrup_pkg.sv
// constants and types for the hidden clock unlock host
package hrup_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int  CLK_PERIOD_NS                = 50;
  localparam real POWERUP_DESELECT_DELAY_MS    = 2.5;
  localparam int  WRITE_PULSE_WIDTH_NS         = 75;
  localparam int  READ_ACCESS_NS               = 85;
  localparam int  DEV_RESET_PULSE_NS           = 65;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int POWERUP_CYC = int'($ceil(POWERUP_DESELECT_DELAY_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int WRITE_CYC   = ns_to_cyc(WRITE_PULSE_WIDTH_NS);
  localparam int READ_CYC    = ns_to_cyc(READ_ACCESS_NS);
  localparam int RESET_CYC   = ns_to_cyc(DEV_RESET_PULSE_NS);

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int ADDR_W    = 17;
  localparam int DATA_W    = 8;
  localparam int TMR_W     = 16;
  localparam int KEY_BITS  = 64;
  localparam int XFER_BITS = 64;
  localparam int FIFO_DEPTH = 8;
  localparam logic [5:0] LAST_BIT = 6'h3F;
  localparam logic [2:0] LAST_BIT_OF_BYTE = 3'h7;
  localparam logic [2:0] FIRST_BIT_OF_BYTE = 3'h0;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {PH_POWER, PH_IDLE, PH_STROBE, PH_RECOVER, PH_RESET} hrup_phase_t;
  typedef enum logic [1:0] {SG_NONE, SG_OPEN, SG_KEY, SG_XFER} hrup_stage_t;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
  } hrup_pins_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
  } hrup_cmd_t;

  localparam hrup_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1,
                                       addr: '0, dq_out: '0, dq_oe_n: 1'b1};

endpackage : hrup_pkg

//--- design/hrup_host.sv
// host sequencer for the hidden clock behind a battery-backed sram
`timescale 1ns/1ps
`default_nettype none
// Contract
// - wait deselect delay before chip select
// - key is 64 writes on bit zero
// - open with one read cycle
// - use one scratch address for key
// - key sent lsb first
// - registers 0 to 7, bit 0 first

// --------------------------------------------------------------------------
// fifo
// --------------------------------------------------------------------------
module hrup_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } hrup_fifo_st_t;

  hrup_fifo_st_t st;
  hrup_fifo_st_t next_st;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  assign in_ready  = (st.cnt != (AW+1)'(D));
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = bump(st.wp);
    end
    if (pop)
      next_st.rp = bump(st.rp);
    if (push && !pop)
      next_st.cnt = (AW+1)'(st.cnt + 1'b1);
    else if (pop && !push)
      next_st.cnt = (AW+1)'(st.cnt - 1'b1);
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end
endmodule : hrup_fifo

// --------------------------------------------------------------------------
// sequencer
// --------------------------------------------------------------------------
module hrup_host #(
  parameter int          PWRUP_CYCLES = hrup_pkg::POWERUP_CYC,
  parameter logic [63:0] UNLOCK_KEY   = 64'h0000_0000_0000_0000
) (
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  input  wire logic                        power_good,
  input  wire logic                        abort,
  input  wire logic                        cmd_valid,
  input  wire hrup_pkg::hrup_cmd_t         cmd,
  output logic                             cmd_ready,
  input  wire logic                        wr_valid,
  input  wire logic [hrup_pkg::DATA_W-1:0] wr_data,
  output logic                             wr_ready,
  output logic                             rd_valid,
  output logic [hrup_pkg::DATA_W-1:0]      rd_data,
  output logic                             done,
  output hrup_pkg::hrup_pins_t             pins,
  input  wire logic [hrup_pkg::DATA_W-1:0] dq_in
);
  typedef struct packed {
    hrup_pkg::hrup_phase_t       phase;
    hrup_pkg::hrup_stage_t       stage;
    logic                        write;
    logic [hrup_pkg::TMR_W-1:0]  tmr;
    logic [5:0]                  cnt;
    logic [hrup_pkg::DATA_W-1:0] sh;
    logic                        rd_valid;
    logic [hrup_pkg::DATA_W-1:0] rd_data;
    logic                        done;
    hrup_pkg::hrup_pins_t        pins;
  } hrup_host_st_t;

  hrup_host_st_t               st;
  hrup_host_st_t               next_st;
  logic                        f_valid;
  logic [hrup_pkg::DATA_W-1:0] f_data;
  logic                        f_pop;
  logic                        need_byte;
  logic                        launch;
  logic                        cyc_write;
  logic                        tx_bit;

  hrup_fifo #(.W(hrup_pkg::DATA_W), .D(hrup_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_pop)
  );

  assign cmd_ready = (st.phase == hrup_pkg::PH_IDLE) && (st.stage == hrup_pkg::SG_NONE)
                     && power_good && !abort;
  assign need_byte = (st.stage == hrup_pkg::SG_XFER) && st.write
                     && (st.cnt[2:0] == hrup_pkg::FIRST_BIT_OF_BYTE);
  assign launch    = (st.phase == hrup_pkg::PH_IDLE) && (st.stage != hrup_pkg::SG_NONE)
                     && power_good && !abort && !(need_byte && !f_valid);
  assign f_pop     = launch && need_byte;
  // the opening cycle is a read; key cycles are writes; transfer follows the command
  assign cyc_write = (st.stage == hrup_pkg::SG_KEY)
                     || ((st.stage == hrup_pkg::SG_XFER) && st.write);
  assign tx_bit    = (st.stage == hrup_pkg::SG_KEY) ? UNLOCK_KEY[st.cnt]
                   : (f_pop ? f_data[0] : st.sh[0]);

  assign rd_valid = st.rd_valid;
  assign rd_data  = st.rd_data;
  assign done     = st.done;
  assign pins     = st.pins;

  always_comb
  begin
    next_st          = st;
    next_st.rd_valid = 1'b0;
    next_st.done     = 1'b0;
    unique case (st.phase)
      hrup_pkg::PH_POWER:
      begin
        next_st.tmr = hrup_pkg::TMR_W'(st.tmr + 1'b1);
        if (st.tmr == hrup_pkg::TMR_W'(PWRUP_CYCLES - 1))
        begin
          next_st.phase = hrup_pkg::PH_IDLE;
          next_st.tmr   = '0;
        end
      end
      hrup_pkg::PH_IDLE:
      begin
        if (cmd_ready && cmd_valid)
        begin
          next_st.stage     = hrup_pkg::SG_OPEN;
          next_st.write     = cmd.write;
          next_st.cnt       = '0;
          next_st.pins.addr = cmd.addr;
        end
        else if (launch)
        begin
          next_st.phase        = hrup_pkg::PH_STROBE;
          next_st.tmr          = '0;
          next_st.pins.ce_n    = 1'b0;
          next_st.pins.we_n    = !cyc_write;
          next_st.pins.oe_n    = cyc_write;
          next_st.pins.dq_oe_n = !cyc_write;
          next_st.pins.dq_out  = {{(hrup_pkg::DATA_W-1){1'b0}}, tx_bit};
          if (f_pop)
            next_st.sh = f_data;
        end
      end
      hrup_pkg::PH_STROBE:
      begin
        next_st.tmr = hrup_pkg::TMR_W'(st.tmr + 1'b1);
        // both strobes rise together after the full overlap
        if (st.tmr == hrup_pkg::TMR_W'((st.pins.we_n ? hrup_pkg::READ_CYC
                                                     : hrup_pkg::WRITE_CYC) - 1))
        begin
          next_st.phase     = hrup_pkg::PH_RECOVER;
          next_st.pins.ce_n = 1'b1;
          next_st.pins.we_n = 1'b1;
          next_st.pins.oe_n = 1'b1;
          if (st.pins.we_n && (st.stage == hrup_pkg::SG_XFER))
            next_st.sh = {dq_in[0], st.sh[hrup_pkg::DATA_W-1:1]};
        end
      end
      hrup_pkg::PH_RECOVER:
      begin
        // data held one cycle past the strobes for hold time
        next_st.phase        = hrup_pkg::PH_IDLE;
        next_st.pins.dq_oe_n = 1'b1;
        next_st.cnt          = 6'(st.cnt + 1'b1);
        unique case (st.stage)
          hrup_pkg::SG_OPEN:
          begin
            next_st.stage = hrup_pkg::SG_KEY;
            next_st.cnt   = '0;
          end
          hrup_pkg::SG_KEY:
            if (st.cnt == hrup_pkg::LAST_BIT)
              next_st.stage = hrup_pkg::SG_XFER;
          hrup_pkg::SG_XFER:
          begin
            if (st.write)
              next_st.sh = st.sh >> 1;
            else if (st.cnt[2:0] == hrup_pkg::LAST_BIT_OF_BYTE)
            begin
              next_st.rd_valid = 1'b1;
              next_st.rd_data  = st.sh;
            end
            if (st.cnt == hrup_pkg::LAST_BIT)
            begin
              next_st.stage = hrup_pkg::SG_NONE;
              next_st.done  = 1'b1;
            end
          end
          default:
            next_st.stage = hrup_pkg::SG_NONE;
        endcase
      end
      hrup_pkg::PH_RESET:
      begin
        next_st.tmr = hrup_pkg::TMR_W'(st.tmr + 1'b1);
        if (st.tmr == hrup_pkg::TMR_W'(hrup_pkg::RESET_CYC - 1))
        begin
          next_st.phase      = hrup_pkg::PH_IDLE;
          next_st.pins.rst_n = 1'b1;
        end
      end
      default:
        next_st.phase = hrup_pkg::PH_POWER;
    endcase
    if (abort && (st.phase != hrup_pkg::PH_POWER) && (st.phase != hrup_pkg::PH_RESET))
    begin
      next_st.phase      = hrup_pkg::PH_RESET;
      next_st.stage      = hrup_pkg::SG_NONE;
      next_st.tmr        = '0;
      next_st.pins       = hrup_pkg::PINS_IDLE;
      next_st.pins.rst_n = 1'b0;
    end
    if (!power_good)
    begin
      next_st.phase = hrup_pkg::PH_POWER;
      next_st.stage = hrup_pkg::SG_NONE;
      next_st.tmr   = '0;
      next_st.pins  = hrup_pkg::PINS_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st       <= '0;
      st.phase <= hrup_pkg::PH_POWER;
      st.stage <= hrup_pkg::SG_NONE;
      st.pins  <= hrup_pkg::PINS_IDLE;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_write_low;
    !pins.ce_n && !pins.we_n;
  endsequence
  sequence s_released;
    pins.ce_n && pins.we_n && pins.oe_n;
  endsequence

  a_power_block: assert property (!power_good |=> pins.ce_n)
    else $error("chip select low while supply bad");
  a_powerup_wait: assert property ($rose(power_good) |=> pins.ce_n [*8])
    else $error("chip select low inside deselect delay");
  a_write_pulse: assert property ($fell(pins.we_n) |-> s_write_low [*2] ##1 s_released)
    else $error("write overlap not two cycles");
  a_write_oe_high: assert property (!pins.we_n |-> pins.oe_n && !pins.dq_oe_n)
    else $error("output enable low in a write");
  a_we_with_ce: assert property ($fell(pins.ce_n) |-> (pins.we_n == !pins.oe_n))
    else $error("write strobe not with chip select");
  a_key_bit: assert property ((st.stage == hrup_pkg::SG_KEY) && !pins.we_n
                              |-> pins.dq_out[0] == UNLOCK_KEY[st.cnt])
    else $error("wrong key bit driven");
  a_open_is_read: assert property ((st.stage == hrup_pkg::SG_OPEN) && !pins.ce_n
                                   |-> pins.we_n && !pins.oe_n)
    else $error("opening cycle is not a read");
  a_key_no_read: assert property ((st.stage == hrup_pkg::SG_KEY) && !pins.ce_n
                                  |-> !pins.we_n)
    else $error("read issued during key");
  a_read_bus_free: assert property (!pins.oe_n |-> pins.dq_oe_n)
    else $error("host drives data during a read");
  a_done_ends: assert property (done |-> st.stage == hrup_pkg::SG_NONE && $past(st.cnt) == 6'h3F)
    else $error("done without full transfer");
  a_abort_reset: assert property (abort && power_good && (st.phase != hrup_pkg::PH_POWER)
                                  && (st.phase != hrup_pkg::PH_RESET)
                                  |=> !pins.rst_n [*2] ##1 pins.rst_n)
    else $error("device reset pulse wrong");
endmodule : hrup_host
`default_nettype wire

//--- bench/hrup_dev_model.sv
// behavioural battery-backed sram with the hidden clock port
`timescale 1ns/1ps
`default_nettype none
module hrup_dev_model #(
  parameter logic [63:0] KEY  = 64'h0,
  parameter logic [63:0] INIT = 64'h0
) (
  input  wire logic        power_good,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  dq,
  output logic [7:0]       dq_drv,
  output logic             xfer_on,
  output logic [63:0]      regs_q
);
  logic [7:0]  mem [logic [16:0]];
  logic [63:0] regs  = INIT;
  logic [6:0]  ptr   = 7'h00;
  logic [6:0]  cnt   = 7'h00;
  logic        miss  = 1'b0;
  logic        armed = 1'b0;
  logic [7:0]  last  = 8'h00;
  logic        dq_en;
  // only own chip select counts, other-chip cycles pass unseen
  wire         sel_wr = power_good && !ce_n && !we_n;
  wire         sel_rd = power_good && !ce_n && we_n;

  assign regs_q = regs;
  // released bus shows the inverse of the last driven byte
  always @*
  begin
    dq_en = sel_rd && !oe_n;
    if (!dq_en)
      dq_drv = ~last;
    else if (xfer_on)
      dq_drv = {7'h00, regs[cnt[5:0]]};
    else
      dq_drv = mem.exists(addr) ? mem[addr] : 8'h00;
    if (dq_en)
      last = dq_drv;
  end

  initial xfer_on = 1'b0;
  always @(posedge power_good) armed = 1'b1;

  always @(negedge sel_wr)
  begin
    if (power_good && xfer_on)
    begin
      regs[cnt[5:0]] = dq[0];
      cnt = cnt + 7'h01;
      xfer_on = (cnt != 7'd64);
    end
    else if (power_good)
    begin
      mem[addr] = dq;
      if (!miss && dq[0] === KEY[ptr[5:0]])
        ptr = ptr + 7'h01;
      else
        miss = 1'b1;
      if (ptr == 7'd64)
      begin
        xfer_on = 1'b1;
        cnt = 7'h00;
        ptr = 7'h00;
      end
    end
  end

  always @(negedge sel_rd)
  begin
    if (power_good && xfer_on)
    begin
      cnt = cnt + 7'h01;
      xfer_on = (cnt != 7'd64);
    end
    else if (power_good)
    begin
      ptr = 7'h00;
      miss = 1'b0;
    end
  end

  // reset-ignore bit is bit 4 of register 4
  always @(negedge rst_n)
  begin
    if (!regs[36])
    begin
      xfer_on = 1'b0;
      ptr = 7'h00;
      miss = 1'b0;
    end
  end
endmodule : hrup_dev_model
`default_nettype wire

//--- bench/test_hidden_rtc_unlock_port.sv
// self-checking bench of the hidden clock unlock host
`timescale 1ns/1ps
`default_nettype none
module test_hidden_rtc_unlock_port;
  localparam int          PWR  = 10;
  localparam logic [63:0] KEY  = 64'h5A3C_96E1_0F78_D24B;
  localparam logic [63:0] INIT = 64'h2307_1512_0930_4511;
  localparam logic [63:0] NEWV = 64'h9908_0701_0623_5942;
  localparam logic [16:0] SCR  = 17'h1FFF0;

  logic                 sys_clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 power_good = 1'b1;
  logic                 abort = 1'b0;
  logic                 cmd_valid = 1'b0;
  hrup_pkg::hrup_cmd_t  cmd = '0;
  logic                 wr_valid = 1'b0;
  logic [7:0]           wr_data = 8'h00;
  logic                 cmd_ready, wr_ready, rd_valid, done, xfer_on;
  logic [7:0]           rd_data, dev_drv, dq_in;
  logic [63:0]          regs_q;
  hrup_pkg::hrup_pins_t pins;
  int                   failures = 0;
  int                   n_tests = 0;
  int                   wlen = 0;

  always #25 sys_clk = ~sys_clk;
  assign dq_in = !pins.dq_oe_n ? pins.dq_out : dev_drv;

  hrup_host #(.PWRUP_CYCLES(PWR), .UNLOCK_KEY(KEY)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .power_good(power_good), .abort(abort),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done), .pins(pins), .dq_in(dq_in));

  hrup_dev_model #(.KEY(KEY), .INIT(INIT)) u_dev (
    .power_good(power_good), .ce_n(pins.ce_n), .oe_n(pins.oe_n), .we_n(pins.we_n),
    .rst_n(pins.rst_n), .addr(pins.addr), .dq(dq_in), .dq_drv(dev_drv),
    .xfer_on(xfer_on), .regs_q(regs_q));

  task automatic tick();
    @(posedge sys_clk);
    #5;
  endtask : tick

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // cycles until cmd_ready, ce_n watched meanwhile
  task automatic wait_up(output int n);
    n = 0;
    while (cmd_ready !== 1'b1 && n < PWR + 50)
    begin
      chk(pins.ce_n, 1'b1);
      tick();
      n++;
    end
  endtask : wait_up

  task automatic run_cmd(input logic wr, input int stop, output logic [63:0] got);
    int k;
    int n;
    k = 0;
    got = '0;
    wait_up(n);
    cmd_valid = 1'b1;
    cmd = '{write: wr, addr: SCR};
    tick();
    cmd_valid = 1'b0;
    for (int i = 0; i < stop && done !== 1'b1; i++)
    begin
      tick();
      if (rd_valid === 1'b1 && k < 8)
      begin
        got[k*8+:8] = rd_data;
        k++;
      end
    end
  endtask : run_cmd

  task automatic t_read(input logic [63:0] exp);
    logic [63:0] got;
    run_cmd(1'b0, 700, got);
    chk(done, 1'b1);
    chk(got, exp);
    tick();
    chk(xfer_on, 1'b0);
    $display("test read done");
  endtask : t_read

  task automatic t_write();
    logic [63:0] got;
    for (int i = 0; i < 8; i++)
    begin
      wr_valid = 1'b1;
      wr_data = NEWV[i*8+:8];
      chk(wr_ready, 1'b1);
      tick();
    end
    wr_data = 8'hEE;
    chk(wr_ready, 1'b0);
    wr_valid = 1'b0;
    run_cmd(1'b1, 700, got);
    chk(done, 1'b1);
    chk(regs_q, NEWV);
    $display("test write done");
  endtask : t_write

  task automatic t_abort();
    logic [63:0] got;
    logic        low;
    run_cmd(1'b0, 300, got);
    chk(xfer_on, 1'b1);
    abort = 1'b1;
    tick();
    abort = 1'b0;
    low = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      low |= (pins.rst_n === 1'b0);
      chk(done, 1'b0);
      tick();
    end
    chk(low, 1'b1);
    chk(xfer_on, 1'b0);
    $display("test abort done");
  endtask : t_abort

  task automatic t_power();
    logic [63:0] got;
    int          n;
    run_cmd(1'b0, 100, got);
    power_good = 1'b0;
    tick();
    tick();
    chk(pins.ce_n, 1'b1);
    chk(cmd_ready, 1'b0);
    repeat (20) tick();
    power_good = 1'b1;
    wait_up(n);
    chk(n >= PWR && n <= PWR + 2, 1'b1);
    $display("test power done");
  endtask : t_power

  always @(negedge sys_clk)
  begin
    if (resetn && !pins.ce_n && !pins.we_n)
      wlen++;
    else if (wlen != 0)
    begin
      chk(64'(wlen), 64'(hrup_pkg::WRITE_CYC));
      wlen = 0;
    end
    if (pins.we_n === 1'b0)
      chk(pins.oe_n, 1'b1);
  end

  initial
  begin
    #2ms;
    failures++;
    wrap_up();
  end

  initial
  begin
    int n;
    repeat (5) tick();
    chk(pins, hrup_pkg::PINS_IDLE);
    chk(cmd_ready, 1'b0);
    resetn = 1'b1;
    wait_up(n);
    chk(n >= PWR && n <= PWR + 2, 1'b1);
    t_read(INIT);
    t_write();
    t_read(NEWV);
    t_abort();
    t_read(NEWV);
    t_power();
    t_read(NEWV);
    wrap_up();
  end
endmodule : test_hidden_rtc_unlock_port
`default_nettype wire
